// *** logic/rtc_params.svh ***
/*
 * Constants of the hidden timekeeper: key, register layout, reset image
 * and tick timing. Assumes a 100 MHz system clock.
 */
// Functional notes
// - Key C5,3A,A3,5C twice, LSB first
// - Hours bit 7 high selects 12-hour mode
// - 12-hour mode: hours bit 5 is PM
// - 24-hour mode: hours bit 5 is tens
// - Day bit 4 high ignores reset pin
// - Day bit 4 low: reset pin aborts transfer
// - Day bit 5 high stops the oscillator
// - Reset-ignore and oscillator-stop bits reset high
// - Unused bits in registers 1-6 read zero
// - Mismatch freezes pointer, ignores later writes
// - Read during recognition restarts at bit zero
// - Transfer walks 64 bits, register 0 first
`ifndef RTC_PARAMS_SVH
`define RTC_PARAMS_SVH
`define KEY_PATTERN 64'h5CA33AC55CA33AC5
`define REG_MASKS 64'hFF1F3F37BF7F7FFF
`define REG_RESET 64'h0001013100000000
`define HOURS_IDX 3'h3
`define DAY_IDX 3'h4
`define HOUR_FMT_BIT 7
`define HALF_DAY_BIT 5
`define RST_IGN_BIT 4
`define OSC_STOP_BIT 5
`define LAST_BIT 6'h3F
`define CLK_PERIOD_NS 32'h0000000A
`define TICK_NS 32'h00989680
`define TICK_CYC (`TICK_NS / `CLK_PERIOD_NS)
`endif

// *** logic/rtc_pkg.sv ***
/*
 * Types shared by the hidden timekeeper.
 * Assumes rtc_params.svh supplies the numbers.
 */
package rtc_pkg;
    typedef enum logic {ST_HUNT, ST_XFER} xfer_state_type;
    typedef struct packed {
        logic data;
        logic [5:0] idx;
    } wbit_type;
    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic dq;
        logic rst_n;
    } pins_type;
endpackage : rtc_pkg

// *** logic/hidden_rtc.sv ***
/*
 * Hidden timekeeper that listens to SRAM strobes: key recognition,
 * 64-bit serial transfer on the data lane and a BCD time chain.
 * Assumes strobes far slower than the clock (each level held three cycles).
 */
`timescale 1ns/1ps
`include "rtc_params.svh"
module hidden_rtc #(
    parameter logic [19:0] TICK_CYC = 20'(`TICK_CYC)
) (
    input wire logic clk_in, // System clock
    input wire logic rst_in, // Async reset, active high
    input wire logic chip_en_n_in, // Chip enable pin
    input wire logic out_en_n_in, // Output enable pin
    input wire logic wr_en_n_in, // Write enable pin
    input wire logic serial_data_lane_in, // Data bit 0 input
    input wire logic reset_pin_n_in, // Transfer reset pin
    output logic serial_data_lane_out, // Data bit 0 output
    output logic serial_data_lane_oe_n_out, // Low while driving
    output logic mem_inhibit_out, // High while clock owns cycles
    output logic osc_running_out // Oscillator running
);
    default clocking sva_clk @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] top);
        logic [8:0] r;
        if (v == top) begin
            r = 9'h100;
        end else if (v[3:0] == 4'h9) begin
            r = {1'b0, v[7:4] + 4'h1, 4'h0};
        end else begin
            r = {1'b0, v[7:4], v[3:0] + 4'h1};
        end
        return r;
    endfunction : bcd_inc

    function automatic logic [7:0] hour_inc(input logic [7:0] v);
        logic [8:0] t;
        logic [7:0] r;
        t = bcd_inc({2'h0, v[5:0]}, 8'h23);
        r = {v[7:6], t[5:0]};
        if (v[`HOUR_FMT_BIT]) begin
            t = bcd_inc({3'h0, v[4:0]}, 8'h12);
            r = {v[7:5], t[4:0]};
            if (v[4:0] == 5'h12) begin
                r = {v[7:5], 5'h01};
            end else if (v[4:0] == 5'h11) begin
                r = {v[7:6], ~v[`HALF_DAY_BIT], 5'h12};
            end
        end
        return r;
    endfunction : hour_inc

    function automatic logic [7:0] reg_mask(input logic [2:0] i);
        logic [63:0] m;
        m = `REG_MASKS;
        return m[{i, 3'h0} +: 8];
    endfunction : reg_mask

    rtc_pkg::pins_type raw, s1_ff, s2_ff;
    rtc_pkg::xfer_state_type state_ff, nxt_state;
    rtc_pkg::wbit_type fifo_ff [2];
    rtc_pkg::wbit_type pend_ff, head;
    logic [7:0] regs_ff [8];
    logic [7:0] nxt_regs [8];
    logic [63:0] snap_ff, key;
    logic [5:0] ptr_ff, nxt_ptr, xcnt_ff, nxt_xcnt;
    logic miss_ff, nxt_miss, wr_prev_ff, rd_prev_ff, dq_hold_ff;
    logic pend_vld_ff, wp_ff, rp_ff, tick_ff;
    logic [1:0] cnt_ff;
    logic [19:0] tick_cnt_ff;
    logic [7:0] asm_ff, nxt_asm;
    logic dq_out_ff, dq_oe_n_ff, inh_ff, osc_ff;

    assign raw = '{ce_n: chip_en_n_in, oe_n: out_en_n_in, we_n: wr_en_n_in,
                   dq: serial_data_lane_in, rst_n: reset_pin_n_in};
    assign key = `KEY_PATTERN;
    localparam logic [63:0] RST_IMG = `REG_RESET;

    // Pins cross in through two flops before any decode.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s1_ff <= 5'h1F;
            s2_ff <= 5'h1F;
        end else begin
            s1_ff <= raw;
            s2_ff <= s1_ff;
        end
    end

    wire wr_act = ~s2_ff.ce_n & ~s2_ff.we_n;
    wire rd_act = ~s2_ff.ce_n & ~s2_ff.oe_n & s2_ff.we_n;
    wire wr_end = wr_prev_ff & ~wr_act;
    wire rd_end = rd_prev_ff & ~rd_act;
    wire cyc_end = wr_end | rd_end;
    wire in_xfer = state_ff == rtc_pkg::ST_XFER;
    wire key_hit = dq_hold_ff == key[ptr_ff];
    wire osc_on = ~regs_ff[`DAY_IDX][`OSC_STOP_BIT];
    wire abort = in_xfer & ~s2_ff.rst_n & ~regs_ff[`DAY_IDX][`RST_IGN_BIT];
    wire ev_wr = in_xfer & wr_end & ~abort;
    wire push = pend_vld_ff & (cnt_ff != 2'h2);
    // The drain stalls on a tick or an abort, so no commit races either of them.
    wire pop = (cnt_ff != 2'h0) & ~tick_ff & ~abort;
    assign head = fifo_ff[rp_ff];
    wire commit = pop & (head.idx[2:0] == 3'h7);

    always_comb begin
        nxt_state = state_ff;
        nxt_ptr = ptr_ff;
        nxt_miss = miss_ff;
        nxt_xcnt = xcnt_ff;
        case (state_ff)
            rtc_pkg::ST_HUNT: begin
                if (rd_end) begin
                    nxt_ptr = 6'h00;
                    nxt_miss = 1'b0;
                end else if (wr_end & ~miss_ff) begin
                    if (!key_hit) begin
                        nxt_miss = 1'b1;
                    end else if (ptr_ff == `LAST_BIT) begin
                        nxt_state = rtc_pkg::ST_XFER;
                        nxt_ptr = 6'h00;
                        nxt_xcnt = 6'h00;
                    end else begin
                        nxt_ptr = ptr_ff + 6'h01;
                    end
                end
            end
            rtc_pkg::ST_XFER: begin
                if (abort) begin
                    nxt_state = rtc_pkg::ST_HUNT;
                    nxt_miss = 1'b0;
                end else if (cyc_end) begin
                    nxt_xcnt = xcnt_ff + 6'h01;
                    if (xcnt_ff == `LAST_BIT) begin
                        nxt_state = rtc_pkg::ST_HUNT;
                    end
                end
            end
            default: begin
                nxt_state = rtc_pkg::ST_HUNT;
            end
        endcase
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_ff <= rtc_pkg::ST_HUNT;
            ptr_ff <= 6'h00;
            miss_ff <= 1'b0;
            xcnt_ff <= 6'h00;
            wr_prev_ff <= 1'b0;
            rd_prev_ff <= 1'b0;
            dq_hold_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            ptr_ff <= nxt_ptr;
            miss_ff <= nxt_miss;
            xcnt_ff <= nxt_xcnt;
            wr_prev_ff <= wr_act;
            rd_prev_ff <= rd_act;
            dq_hold_ff <= wr_act ? s2_ff.dq : dq_hold_ff;
        end
    end

    // Two-entry buffer between write cycles and the register commit.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pend_vld_ff <= 1'b0;
            pend_ff <= 7'h00;
            wp_ff <= 1'b0;
            rp_ff <= 1'b0;
            cnt_ff <= 2'h0;
            fifo_ff[0] <= 7'h00;
            fifo_ff[1] <= 7'h00;
        end else if (abort) begin
            pend_vld_ff <= 1'b0;
            cnt_ff <= 2'h0;
            rp_ff <= wp_ff;
        end else begin
            pend_vld_ff <= ev_wr | (pend_vld_ff & ~push);
            pend_ff <= ev_wr ? rtc_pkg::wbit_type'{data: dq_hold_ff, idx: xcnt_ff} : pend_ff;
            if (push) begin
                fifo_ff[wp_ff] <= pend_ff;
            end
            wp_ff <= wp_ff ^ push;
            rp_ff <= rp_ff ^ pop;
            cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
        end
    end

    always_comb begin
        nxt_asm = asm_ff;
        nxt_asm[head.idx[2:0]] = head.data;
    end

    wire [8:0] hs_inc = bcd_inc(regs_ff[0], 8'h99);
    wire [8:0] sec_inc = bcd_inc(regs_ff[1], 8'h59);
    wire [8:0] min_inc = bcd_inc(regs_ff[2], 8'h59);
    wire hr_carry = tick_ff & hs_inc[8] & sec_inc[8] & min_inc[8];

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            nxt_regs[i] = regs_ff[i];
        end
        if (tick_ff) begin
            nxt_regs[0] = hs_inc[7:0];
            if (hs_inc[8]) begin
                nxt_regs[1] = sec_inc[7:0];
            end
            if (hs_inc[8] & sec_inc[8]) begin
                nxt_regs[2] = min_inc[7:0];
            end
            if (hr_carry) begin
                nxt_regs[`HOURS_IDX] = hour_inc(regs_ff[`HOURS_IDX]);
            end
        end
        if (commit) begin
            nxt_regs[head.idx[5:3]] = nxt_asm & reg_mask(head.idx[5:3]);
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < 8; i++) begin
                regs_ff[i] <= RST_IMG[i*8 +: 8];
            end
            asm_ff <= 8'h00;
        end else begin
            for (int i = 0; i < 8; i++) begin
                regs_ff[i] <= nxt_regs[i];
            end
            asm_ff <= pop ? nxt_asm : asm_ff;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            tick_cnt_ff <= 20'h00000;
            tick_ff <= 1'b0;
        end else begin
            tick_ff <= osc_on & (tick_cnt_ff == TICK_CYC - 20'h1);
            if (!osc_on || tick_cnt_ff == TICK_CYC - 20'h1) begin
                tick_cnt_ff <= 20'h00000;
            end else begin
                tick_cnt_ff <= tick_cnt_ff + 20'h1;
            end
        end
    end

    wire [63:0] img = {regs_ff[7], regs_ff[6], regs_ff[5], regs_ff[4],
                       regs_ff[3], regs_ff[2], regs_ff[1], regs_ff[0]};
    wire unlock = ~in_xfer & (nxt_state == rtc_pkg::ST_XFER);

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            snap_ff <= 64'h0;
            dq_out_ff <= 1'b0;
            dq_oe_n_ff <= 1'b1;
            inh_ff <= 1'b0;
            osc_ff <= 1'b0;
        end else begin
            snap_ff <= unlock ? img : snap_ff;
            // Bit 0 of register 0 first.
            dq_out_ff <= snap_ff[xcnt_ff];
            dq_oe_n_ff <= ~(in_xfer & rd_act & ~abort);
            inh_ff <= nxt_state == rtc_pkg::ST_XFER;
            osc_ff <= osc_on;
        end
    end

    assign serial_data_lane_out = dq_out_ff;
    assign serial_data_lane_oe_n_out = dq_oe_n_ff;
    assign mem_inhibit_out = inh_ff;
    assign osc_running_out = osc_ff;

    wire zero_ok = ((regs_ff[1] & ~reg_mask(3'h1)) == 8'h00)
                 & ((regs_ff[2] & ~reg_mask(3'h2)) == 8'h00)
                 & ((regs_ff[3] & ~reg_mask(3'h3)) == 8'h00)
                 & ((regs_ff[4] & ~reg_mask(3'h4)) == 8'h00)
                 & ((regs_ff[5] & ~reg_mask(3'h5)) == 8'h00)
                 & ((regs_ff[6] & ~reg_mask(3'h6)) == 8'h00);

    property p_key_step;
        (!in_xfer && !rd_end && wr_end && !miss_ff && key_hit && ptr_ff != 6'h3F)
        |=> ptr_ff == $past(ptr_ff) + 6'h01;
    endproperty
    a_key_step: assert property (p_key_step) else $error("key pointer did not step");
    property p_miss_hold;
        (!in_xfer && miss_ff && !rd_end) |=> $stable(ptr_ff) && miss_ff;
    endproperty
    a_miss_hold: assert property (p_miss_hold) else $error("pointer moved after miss");
    property p_read_restart;
        (!in_xfer && rd_end) |=> ptr_ff == 6'h00 && !miss_ff;
    endproperty
    a_read_restart: assert property (p_read_restart) else $error("read did not restart");
    sequence s_last_hit;
        !in_xfer && !rd_end && wr_end && !miss_ff && key_hit && ptr_ff == 6'h3F;
    endsequence
    property p_unlock;
        s_last_hit |=> in_xfer && xcnt_ff == 6'h00 ##1 mem_inhibit_out;
    endproperty
    a_unlock: assert property (p_unlock) else $error("unlock missed");
    property p_xfer_end;
        (in_xfer && !abort && cyc_end && xcnt_ff == 6'h3F) |=> !in_xfer ##1 !mem_inhibit_out;
    endproperty
    a_xfer_end: assert property (p_xfer_end) else $error("transfer length wrong");
    property p_abort;
        (in_xfer && !s2_ff.rst_n && !regs_ff[`DAY_IDX][`RST_IGN_BIT] && !hr_carry)
        |=> !in_xfer && $stable(regs_ff[`HOURS_IDX]);
    endproperty
    a_abort: assert property (p_abort) else $error("reset pin did not abort");
    property p_ignore;
        (in_xfer && regs_ff[`DAY_IDX][`RST_IGN_BIT] && !cyc_end) |=> in_xfer;
    endproperty
    a_ignore: assert property (p_ignore) else $error("ignored pin aborted");
    property p_zero_bits;
        zero_ok;
    endproperty
    a_zero_bits: assert property (p_zero_bits) else $error("unused bit set");
    // A tick already launched when the stop bit lands is the last one allowed.
    property p_osc_stop;
        (regs_ff[`DAY_IDX][`OSC_STOP_BIT] && !commit && !tick_ff)
        |=> $stable(regs_ff[0]) && !tick_ff;
    endproperty
    a_osc_stop: assert property (p_osc_stop) else $error("stopped clock counted");
    property p_wrap24;
        (hr_carry && !commit && regs_ff[`HOURS_IDX] == 8'h23) |=> regs_ff[`HOURS_IDX] == 8'h00;
    endproperty
    a_wrap24: assert property (p_wrap24) else $error("24-hour wrap wrong");
    property p_noon;
        (hr_carry && !commit && regs_ff[`HOURS_IDX] == 8'h91) |=> regs_ff[`HOURS_IDX] == 8'hB2;
    endproperty
    a_noon: assert property (p_noon) else $error("12-hour PM flip wrong");
endmodule : hidden_rtc

// *** sim/host_bfm.sv ***
/*
 * Host side model of the hidden timekeeper: drives the SRAM strobes and the
 * data lane in whole pin cycles. Assumes the system clock runs free and that
 * the bench resolves the lane from the device enable alone.
 */
`timescale 1ns/1ps
module host_bfm (
    input wire logic clk_in, // System clock
    input wire logic dq_wire_in, // Resolved data lane
    output logic ce_n_out, // Chip enable, active low
    output logic oe_n_out, // Output enable, active low
    output logic we_n_out, // Write enable, active low
    output logic dq_out // Host drive of the lane
);
    localparam logic [63:0] KEY = {8'h5C, 8'hA3, 8'h3A, 8'hC5, 8'h5C, 8'hA3, 8'h3A, 8'hC5};
    logic bit_ff;
    logic drive_ff;
    logic idle_ff;

    // A released lane toggles so that a stale bit cannot pass for data.
    assign dq_out = drive_ff ? bit_ff : idle_ff;

    initial begin
        ce_n_out = 1'h1;
        oe_n_out = 1'h1;
        we_n_out = 1'h1;
        bit_ff = 1'h0;
        drive_ff = 1'h0;
        idle_ff = 1'h0;
    end

    always @(posedge clk_in) begin
        idle_ff <= ~idle_ff;
    end

    // Each strobe level lasts four clocks, one more than the synchroniser needs.
    task automatic write_bit(input logic b);
        @(posedge clk_in);
        ce_n_out <= 1'h0;
        we_n_out <= 1'h0;
        bit_ff <= b;
        drive_ff <= 1'h1;
        repeat (4) @(posedge clk_in);
        ce_n_out <= 1'h1;
        we_n_out <= 1'h1;
        repeat (2) @(posedge clk_in);
        drive_ff <= 1'h0;
        repeat (2) @(posedge clk_in);
    endtask : write_bit

    task automatic read_bit(output logic b);
        @(posedge clk_in);
        ce_n_out <= 1'h0;
        oe_n_out <= 1'h0;
        repeat (4) @(posedge clk_in);
        b = dq_wire_in;
        ce_n_out <= 1'h1;
        oe_n_out <= 1'h1;
        repeat (4) @(posedge clk_in);
    endtask : read_bit

    task automatic send(input logic [63:0] k, input int n);
        for (int i = 0; i < n; i++) begin
            write_bit(k[i]);
        end
    endtask : send

    task automatic unlock();
        logic d;
        read_bit(d);
        send(KEY, 64);
        repeat (3) @(posedge clk_in);
    endtask : unlock

    task automatic read_range(input int lo, input int hi, inout logic [63:0] v);
        logic b;
        for (int i = lo; i <= hi; i++) begin
            read_bit(b);
            v[i] = b;
        end
    endtask : read_range
endmodule : host_bfm

// *** sim/tb_top.sv ***
/*
 * Self-checking bench for the hidden timekeeper: key entry, register image,
 * hour formats, oscillator and reset-pin control.
 * Assumes host_bfm drives the strobes and the clock runs at 100 MHz.
 */
`timescale 1ns/1ps
module tb_top;
    logic clk_in = 1'h0;
    logic rst_in = 1'h1;
    logic reset_pin_n = 1'h1;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic host_dq;
    logic dq_wire;
    logic dev_dq;
    logic dev_oe_n;
    logic inhibit;
    logic osc_run;
    logic [63:0] got = 64'h0;
    int miscompares = 0;
    int num_checks = 0;
    localparam logic [63:0] IMG_X = {8'h24, 8'h08, 8'h15, 8'h22, 8'h07, 8'h56, 8'h34, 8'h12};

    always #5 clk_in = ~clk_in;
    // The lane carries the device bit only while its enable is low.
    assign dq_wire = (dev_oe_n === 1'h0) ? dev_dq : host_dq;

    hidden_rtc #(.TICK_CYC(20'h00004)) u_dut (.clk_in(clk_in), .rst_in(rst_in),
        .chip_en_n_in(ce_n), .out_en_n_in(oe_n), .wr_en_n_in(we_n),
        .serial_data_lane_in(dq_wire), .reset_pin_n_in(reset_pin_n),
        .serial_data_lane_out(dev_dq), .serial_data_lane_oe_n_out(dev_oe_n),
        .mem_inhibit_out(inhibit), .osc_running_out(osc_run));

    host_bfm u_host (.clk_in(clk_in), .dq_wire_in(dq_wire), .ce_n_out(ce_n),
        .oe_n_out(oe_n), .we_n_out(we_n), .dq_out(host_dq));

    task automatic check(input logic [63:0] act, input logic [63:0] exp, input string what);
        num_checks++;
        if (act !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, act, exp);
        end
    endtask : check

    task automatic settle();
        repeat (3) @(posedge clk_in);
        check(64'(inhibit), 64'h0, "inhibit after 64 cycles");
    endtask : settle

    task automatic xfer_read();
        u_host.unlock();
        check(64'(inhibit), 64'h1, "inhibit after key");
        u_host.read_range(0, 63, got);
        settle();
    endtask : xfer_read

    task automatic xfer_write(input logic [63:0] v);
        u_host.unlock();
        u_host.send(v, 64);
        settle();
    endtask : xfer_write

    task automatic pulse_pin();
        @(posedge clk_in);
        reset_pin_n <= 1'h0;
        repeat (8) @(posedge clk_in);
        reset_pin_n <= 1'h1;
        repeat (8) @(posedge clk_in);
    endtask : pulse_pin

    task automatic test_reset_image();
        check(64'(osc_run), 64'h0, "oscillator after reset");
        u_host.unlock();
        u_host.read_range(0, 19, got);
        pulse_pin();
        check(64'(inhibit), 64'h1, "pin while ignored");
        u_host.read_range(20, 63, got);
        settle();
        check(got, 64'h0001013100000000, "reset image");
    endtask : test_reset_image

    task automatic test_zero_bits();
        xfer_write(64'hFFFFFFFFFFFFFFFF);
        xfer_read();
        check(got, 64'hFF1F3F37BF7F7FFF, "zero bits");
    endtask : test_zero_bits

    task automatic test_key_faults();
        logic d;
        u_host.read_bit(d);
        u_host.send(u_host.KEY, 10);
        xfer_read();
        check(got, 64'hFF1F3F37BF7F7FFF, "key after read abort");
        u_host.read_bit(d);
        u_host.send(u_host.KEY ^ 64'h0000000000000020, 64);
        repeat (3) @(posedge clk_in);
        check(64'(inhibit), 64'h0, "wrong key bit");
        u_host.send(u_host.KEY, 64);
        repeat (3) @(posedge clk_in);
        check(64'(inhibit), 64'h0, "writes after mismatch");
    endtask : test_key_faults

    task automatic test_pin_abort();
        xfer_write(IMG_X);
        u_host.unlock();
        u_host.read_range(0, 7, got);
        pulse_pin();
        check(64'(inhibit), 64'h0, "pin abort");
        xfer_read();
        check(got, IMG_X, "image after abort");
    endtask : test_pin_abort

    // The time is loaded stopped, then restarted so one tick rolls hundredths, seconds and minutes into the hours.
    task automatic test_roll(input logic [7:0] hin, input logic [7:0] hexp);
        logic [63:0] img;
        img = {8'h00, 8'h01, 8'h01, 8'h20, hin, 8'h59, 8'h59, 8'h99};
        xfer_write(img);
        check(64'(osc_run), 64'h0, "oscillator stopped");
        img[39:32] = 8'h00;
        xfer_write(img);
        xfer_read();
        check(64'(osc_run), 64'h1, "oscillator running");
        check(64'(got[31:24]), 64'(hexp), "hours after rollover");
    endtask : test_roll

    task automatic conclude();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude

    initial begin
        repeat (12) @(posedge clk_in);
        rst_in <= 1'h0;
        repeat (2) @(posedge clk_in);
        test_reset_image();
        test_zero_bits();
        test_key_faults();
        test_pin_abort();
        test_roll(8'h91, 8'hB2);
        test_roll(8'hB2, 8'hA1);
        test_roll(8'hB1, 8'h92);
        test_roll(8'h19, 8'h20);
        test_roll(8'h23, 8'h00);
        conclude();
    end

    // The sequence needs about 27,000 clocks; the limit allows 50,000.
    initial begin
        #500000;
        $display("unexpected at %0t: watchdog expired", $time);
        miscompares++;
        conclude();
    end
endmodule : tb_top
